// >>> scb_params.svh
// Purpose: Constants for the command conditioning and braking block
// Assumes: 100 MHz clock, 32-bit classic Wishbone register port
// Notes: Byte offsets are word aligned
`ifndef SCB_PARAMS_SVH
`define SCB_PARAMS_SVH

// ==========================================================
// Register byte offsets
`define SCB_OFF_BRAKE_POLICY 8'h00
`define SCB_OFF_RES_OHMS 8'h04
`define SCB_OFF_RES_MAXPWR 8'h08
`define SCB_OFF_HEAT_DECAY 8'h0C
`define SCB_OFF_POL_INV 8'h10
`define SCB_OFF_POS_SRC 8'h14
`define SCB_OFF_STATUS 8'h18
`define SCB_OFF_HEAT 8'h1C
`define SCB_OFF_CTRL 8'h20

// ==========================================================
// Reset values
`define SCB_RST_BRAKE_POLICY 16'h0002
`define SCB_RST_HEAT_DECAY 16'h0032
`define SCB_RST_ZERO 16'h0000

// ==========================================================
// Field positions and limits
`define SCB_INV_POS 0
`define SCB_INV_SPD 1
`define SCB_INV_TRQ 2
`define SCB_INV_MASK 16'h0007
`define SCB_POLICY_MAX 16'h0003
`define SCB_SRC_MAX 16'h0006
`define SCB_DECAY_MAX 16'h0064
`define SCB_CTRL_HIGHV 0
`define SCB_CTRL_NOPULSE 1
`define SCB_ST_BRAKE 0
`define SCB_ST_OVF 1
`define SCB_ST_OVLVL 2

// ==========================================================
// Thresholds in bus-voltage units of 0.1 V
`define SCB_VTH_LOW 16'h0ED8
`define SCB_VTH_HIGH 16'h1A90
`define SCB_VOV_LOW 16'h1068
`define SCB_VOV_HIGH 16'h1D4C

// ==========================================================
// Heat model timing
`define SCB_HEAT_MAX 32'h05F5E100
`define SCB_DECAY_FULL_S 10
`define SCB_CLK_HZ 100000000
`define SCB_DECAY_CYC (`SCB_DECAY_FULL_S * `SCB_CLK_HZ)
// Percent accumulator wrap: at 100 percent one unit per 10 cycles
`define SCB_DECAY_DIV 16'h03E8

`endif

// >>> scb_pkg.sv
// Purpose: Types for the command conditioning and braking block
// Assumes: Used together with scb_params.svh
// Notes: Types only
package scb_pkg;

    typedef struct packed {
        logic [31:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
        logic we;
        logic stb;
        logic cyc;
    } scb_wb_req_type;

    typedef struct packed {
        logic signed [31:0] pulse_cnt;
        logic signed [31:0] enc2_cnt;
        logic signed [31:0] plan_pos;
        logic signed [31:0] speed;
        logic signed [31:0] torque;
    } scb_cmd_in_type;

    typedef struct packed {
        logic signed [31:0] pos;
        logic signed [31:0] speed;
        logic signed [31:0] torque;
        logic pos_valid;
    } scb_cmd_out_type;

    typedef struct packed {
        logic pos_cmd_inhibit_in;
        logic pos_cmd_reverse_in;
        logic pos_source_switch_in;
    } scb_infn_type;

    typedef enum logic [1:0] {
        SCB_BR_NEVER,
        SCB_BR_DECEL,
        SCB_BR_ALWAYS,
        SCB_BR_REGEN
    } scb_policy_type;

endpackage

// >>> scb_servo_cmd_brake.sv
// Purpose: Braking decision, resistor heat estimate, command conditioning
// Assumes: Inputs synchronous to clk; bus voltage in units of 0.1 V
// Notes: Multi-segment planning and stop sequencing live elsewhere
`timescale 1ns/1ps
`include "scb_params.svh"

module scb_servo_cmd_brake
(
    input wire logic clk,
    input wire logic rst_n,
    input wire scb_pkg::scb_wb_req_type wb_req,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [15:0] bus_voltage,
    input wire logic decelerating,
    input wire logic regen_active,
    input wire logic loop_tick,
    input wire scb_pkg::scb_infn_type infn,
    input wire scb_pkg::scb_cmd_in_type cmd_in,
    output scb_pkg::scb_cmd_out_type cmd_out,
    output logic brake_on,
    output logic overvolt_fault,
    output logic [31:0] heat_est
);
    import scb_pkg::*;

    // ======================================================
    // Register bus
    logic [15:0] policy_q;
    logic [15:0] ohms_q;
    logic [15:0] maxpwr_q;
    logic [15:0] decay_q;
    logic [15:0] polinv_q;
    logic [15:0] possrc_q;
    logic [15:0] ctrl_q;
    logic ovf_q;
    logic ack_q;
    logic [31:0] rdat_q;

    wire bus_req = wb_req.cyc & wb_req.stb & ~ack_q;
    // Write lands at the edge where the master samples ack
    wire bus_wr = wb_req.cyc & wb_req.stb & ack_q & wb_req.we;
    wire lo_lane = wb_req.sel[0];
    wire hi_lane = wb_req.sel[1];
    wire [7:0] bus_adr = wb_req.adr[7:0];
    wire [15:0] wdat = wb_req.dat[15:0];
    wire hit_policy = bus_adr == `SCB_OFF_BRAKE_POLICY;
    wire hit_ohms = bus_adr == `SCB_OFF_RES_OHMS;
    wire hit_maxpwr = bus_adr == `SCB_OFF_RES_MAXPWR;
    wire hit_decay = bus_adr == `SCB_OFF_HEAT_DECAY;
    wire hit_polinv = bus_adr == `SCB_OFF_POL_INV;
    wire hit_possrc = bus_adr == `SCB_OFF_POS_SRC;
    wire hit_status = bus_adr == `SCB_OFF_STATUS;
    wire hit_heat = bus_adr == `SCB_OFF_HEAT;
    wire hit_ctrl = bus_adr == `SCB_OFF_CTRL;
    wire full_wr = bus_wr & lo_lane & hi_lane;

    // Out-of-range values are refused so the fields stay legal
    wire wr_policy = full_wr & hit_policy & (wdat <= `SCB_POLICY_MAX);
    wire wr_polinv = full_wr & hit_polinv & (wdat <= `SCB_INV_MASK);
    wire wr_possrc = full_wr & hit_possrc & (wdat <= `SCB_SRC_MAX);
    wire wr_decay = full_wr & hit_decay & (wdat <= `SCB_DECAY_MAX);
    wire wr_ohms = full_wr & hit_ohms;
    wire wr_maxpwr = full_wr & hit_maxpwr;
    wire wr_ctrl = full_wr & hit_ctrl;
    wire clr_ovf = full_wr & hit_status & wdat[`SCB_ST_OVF];

    // ======================================================
    // Braking decision
    wire high_variant = ctrl_q[`SCB_CTRL_HIGHV];
    wire no_pulse_port = ctrl_q[`SCB_CTRL_NOPULSE];
    wire [15:0] vth = high_variant ? `SCB_VTH_HIGH : `SCB_VTH_LOW;
    wire [15:0] vov = high_variant ? `SCB_VOV_HIGH : `SCB_VOV_LOW;
    wire over_th = bus_voltage > vth;
    wire over_ov = bus_voltage > vov;
    scb_policy_type policy;
    assign policy = scb_policy_type'(policy_q[1:0]);
    logic brake_d;
    always_comb
    begin
        case (policy)
            SCB_BR_NEVER: brake_d = 1'b0;
            SCB_BR_DECEL: brake_d = over_th & decelerating;
            SCB_BR_ALWAYS: brake_d = over_th;
            SCB_BR_REGEN: brake_d = over_th & regen_active;
            default: brake_d = 1'b0;
        endcase
    end

    // Set wins over a software clear in the same cycle
    wire ovf_d = over_ov | (ovf_q & ~clr_ovf);

    // ======================================================
    // Heat estimate
    // Heat rises while braking, by maxpwr_q plus one per clock; ohms_q is not used
    logic [31:0] heat_q;
    logic [15:0] dacc_q;
    // Fractional rate: a whole step is far below one unit per cycle
    wire [16:0] dacc_sum = {1'b0, dacc_q} + {1'b0, decay_q};
    wire dec_pulse = dacc_sum >= {1'b0, `SCB_DECAY_DIV};
    wire [16:0] dacc_wrap = dacc_sum - {1'b0, `SCB_DECAY_DIV};
    wire [15:0] dacc_d = dec_pulse ? dacc_wrap[15:0] : dacc_sum[15:0];
    wire [31:0] gain = {16'h0000, maxpwr_q} + 32'h00000001;
    wire [32:0] heat_up = {1'b0, heat_q} + {1'b0, gain};
    wire [31:0] heat_sat = heat_up > {1'b0, `SCB_HEAT_MAX}
        ? `SCB_HEAT_MAX : heat_up[31:0];
    wire [31:0] heat_dn = (dec_pulse && heat_q != 32'h00000000)
        ? heat_q - 32'h00000001 : heat_q;
    wire [31:0] heat_d = brake_on ? heat_sat : heat_dn;

    // ======================================================
    // Position source and conditioning
    logic signed [31:0] pos_sel;
    logic pos_ok;
    wire use_plan = no_pulse_port | (possrc_q[2:0] == 3'h1)
        | ((possrc_q[2:0] == 3'h2) & infn.pos_source_switch_in);
    always_comb
    begin
        pos_ok = 1'b1;
        if (use_plan)
            pos_sel = cmd_in.plan_pos;
        else
        begin
            case (possrc_q[2:0])
                3'h0: pos_sel = cmd_in.pulse_cnt;
                3'h2: pos_sel = cmd_in.pulse_cnt;
                3'h3: pos_sel = cmd_in.pulse_cnt + cmd_in.enc2_cnt;
                3'h4: pos_sel = cmd_in.pulse_cnt + cmd_in.plan_pos;
                default:
                begin
                    // Sources 5 and 6 are generated elsewhere
                    pos_sel = 32'sh00000000;
                    pos_ok = 1'b0;
                end
            endcase
        end
    end
    wire pos_flip = polinv_q[`SCB_INV_POS] ^ infn.pos_cmd_reverse_in;
    wire signed [31:0] pos_cond = pos_flip ? -pos_sel : pos_sel;
    wire signed [31:0] spd_cond = polinv_q[`SCB_INV_SPD]
        ? -cmd_in.speed : cmd_in.speed;
    wire signed [31:0] trq_cond = polinv_q[`SCB_INV_TRQ]
        ? -cmd_in.torque : cmd_in.torque;
    wire pos_block = infn.pos_cmd_inhibit_in | ~pos_ok;
    scb_cmd_out_type cmd_d;
    assign cmd_d.pos = pos_block ? 32'sh00000000 : pos_cond;
    assign cmd_d.speed = spd_cond;
    assign cmd_d.torque = trq_cond;
    assign cmd_d.pos_valid = ~pos_block;

    // ======================================================
    // Read mux
    wire [15:0] status_w = {13'h0000, over_ov, ovf_q, brake_on};
    wire [31:0] rd_w = hit_policy ? {16'h0000, policy_q}
        : hit_ohms ? {16'h0000, ohms_q}
        : hit_maxpwr ? {16'h0000, maxpwr_q}
        : hit_decay ? {16'h0000, decay_q}
        : hit_polinv ? {16'h0000, polinv_q}
        : hit_possrc ? {16'h0000, possrc_q}
        : hit_status ? {16'h0000, status_w}
        : hit_heat ? heat_q
        : hit_ctrl ? {16'h0000, ctrl_q}
        : 32'h00000000;

    // ======================================================
    // Registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            policy_q <= `SCB_RST_BRAKE_POLICY;
            ohms_q <= `SCB_RST_ZERO;
            maxpwr_q <= `SCB_RST_ZERO;
            decay_q <= `SCB_RST_HEAT_DECAY;
            polinv_q <= `SCB_RST_ZERO;
            possrc_q <= `SCB_RST_ZERO;
            ctrl_q <= `SCB_RST_ZERO;
        end
        else
        begin
            if (wr_policy) policy_q <= wdat;
            if (wr_ohms) ohms_q <= wdat;
            if (wr_maxpwr) maxpwr_q <= wdat;
            if (wr_decay) decay_q <= wdat;
            if (wr_polinv) polinv_q <= wdat;
            if (wr_possrc) possrc_q <= wdat;
            if (wr_ctrl) ctrl_q <= wdat;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_q <= 1'b0;
            rdat_q <= 32'h00000000;
        end
        else
        begin
            ack_q <= bus_req;
            rdat_q <= bus_req ? rd_w : 32'h00000000;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            brake_on <= 1'b0;
            ovf_q <= 1'b0;
            overvolt_fault <= 1'b0;
            heat_q <= 32'h00000000;
            heat_est <= 32'h00000000;
            dacc_q <= 16'h0000;
        end
        else
        begin
            brake_on <= brake_d;
            ovf_q <= ovf_d;
            overvolt_fault <= ovf_d;
            heat_q <= heat_d;
            heat_est <= heat_d;
            dacc_q <= dacc_d;
        end
    end

    // Commands refresh each loop tick; settings act on the next one
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cmd_out <= '0;
        else if (loop_tick)
            cmd_out <= cmd_d;
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
endmodule

// >>> scb_sva.sv
// Purpose: Port checks for scb_servo_cmd_brake
// Assumes: One clock, async active-low reset
// Notes: Variant bit is not visible here, so low threshold bounds brake_on
`timescale 1ns/1ps
`include "scb_params.svh"
module scb_sva
(
    input wire logic clk,
    input wire logic rst_n,
    input wire scb_pkg::scb_wb_req_type wb_req,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [15:0] bus_voltage,
    input wire logic loop_tick,
    input wire scb_pkg::scb_infn_type infn,
    input wire scb_pkg::scb_cmd_out_type cmd_out,
    input wire logic brake_on,
    input wire logic overvolt_fault,
    input wire logic [31:0] heat_est
);
    import scb_pkg::*;
    // ====
    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_brake_cause: assert property (brake_on |->
        $past(bus_voltage) > `SCB_VTH_LOW) else $error("brake low bus");
    a_fault_set: assert property (bus_voltage > `SCB_VOV_HIGH |=>
        overvolt_fault) else $error("fault not set");
    a_fault_sticky: assert property (overvolt_fault &&
        !(wb_req.cyc && wb_req.we) |=> overvolt_fault)
        else $error("fault lost");
    a_ack_next: assert property (wb_req.cyc && wb_req.stb && !wb_ack_o
        |=> wb_ack_o) else $error("no ack");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("data without ack");
    a_inhibit_blk: assert property (loop_tick &&
        infn.pos_cmd_inhibit_in |=> !cmd_out.pos_valid && cmd_out.pos == 0)
        else $error("inhibit leak");
    a_cmd_hold: assert property (!loop_tick |=> $stable(cmd_out))
        else $error("cmd moved");
    a_heat_cap: assert property (heat_est <= `SCB_HEAT_MAX)
        else $error("heat over max");
    a_heat_rise: assert property (brake_on && $past(brake_on) |->
        heat_est >= $past(heat_est)) else $error("heat fell braking");
endmodule
bind scb_servo_cmd_brake scb_sva u_sva
(
    .clk(clk),
    .rst_n(rst_n),
    .wb_req(wb_req),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .bus_voltage(bus_voltage),
    .loop_tick(loop_tick),
    .infn(infn),
    .cmd_out(cmd_out),
    .brake_on(brake_on),
    .overvolt_fault(overvolt_fault),
    .heat_est(heat_est)
);

// >>> scb_stage_model.sv
// Purpose: Power stage and bus sensing seen by the block
// Assumes: Sensing lags the set point by one clock
// Notes: Motion state is set by the bench
`timescale 1ns/1ps
module scb_stage_model
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] v_set,
    input wire logic decel_set,
    input wire logic regen_set,
    output logic [15:0] bus_voltage,
    output logic decelerating,
    output logic regen_active
);
    // ====
    // Sensing register, like a real ADC sample
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
        begin
            bus_voltage <= 16'h0000;
            decelerating <= 1'b0;
            regen_active <= 1'b0;
        end
        else
        begin
            bus_voltage <= v_set;
            decelerating <= decel_set;
            regen_active <= regen_set;
        end
endmodule

// >>> tb_top.sv
// Purpose: Self-checking bench for scb_servo_cmd_brake
// Assumes: Wishbone answers one cycle after take
// Notes: Source switch high is taken to pick the planner
`timescale 1ns/1ps
`include "scb_params.svh"
module tb_top;
    import scb_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    scb_wb_req_type wb_req = '0;
    logic [31:0] wb_dat_o, heat_est, rd, h;
    logic wb_ack_o, dec, rgn, brake_on, overvolt_fault;
    logic [15:0] v_set = 16'h0000;
    logic [15:0] bus_v;
    logic dec_set = 1'b0;
    logic rgn_set = 1'b0;
    logic loop_tick = 1'b0;
    scb_infn_type infn = '0;
    scb_cmd_in_type cmd_in = '0;
    scb_cmd_out_type cmd_out;
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc_cnt = 0;
    always #5 clk = ~clk;
    scb_servo_cmd_brake dut (.clk(clk), .rst_n(rst_n), .wb_req(wb_req),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .bus_voltage(bus_v),
        .decelerating(dec), .regen_active(rgn), .loop_tick(loop_tick),
        .infn(infn), .cmd_in(cmd_in), .cmd_out(cmd_out),
        .brake_on(brake_on), .overvolt_fault(overvolt_fault),
        .heat_est(heat_est));
    scb_stage_model u_stage (.clk(clk), .rst_n(rst_n), .v_set(v_set),
        .decel_set(dec_set), .regen_set(rgn_set), .bus_voltage(bus_v),
        .decelerating(dec), .regen_active(rgn));
    // ====
    // Shared tasks
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        wb_req <= '{{24'h0, a}, d, 4'hF, w, 1'b1, 1'b1};
        @(posedge clk);
        while (wb_ack_o !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 20)
        begin
            n_mismatch++;
            $display("BAD %0t no ack", $time);
        end
        rd = wb_dat_o;
        wb_req <= '0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        wb(a, 1'b0, 32'h0);
        chk(rd, e);
    endtask
    task automatic tick;
        @(posedge clk);
        loop_tick <= 1'b1;
        @(posedge clk);
        loop_tick <= 1'b0;
        @(posedge clk);
    endtask
    // ====
    // Scenarios
    task automatic t_regs;
        logic [31:0] ev [6] = '{32'h2, 32'h0, 32'h0, 32'h32, 32'h0, 32'h0};
        for (int i = 0; i < 6; i++)
            rdc(8'(4 * i), ev[i]);
        rdc(8'h40, 32'h0);
        wb(`SCB_OFF_POL_INV, 1'b1, 32'h8);
        rdc(`SCB_OFF_POL_INV, 32'h0);
        wb(`SCB_OFF_BRAKE_POLICY, 1'b1, 32'h4);
        rdc(`SCB_OFF_BRAKE_POLICY, 32'h2);
    endtask
    task automatic t_brake;
        for (int p = 0; p < 5; p++)
            for (int m = 0; m < 8; m++)
            begin
                wb(`SCB_OFF_BRAKE_POLICY, 1'b1, 32'(p == 4 ? 2 : p));
                wb(`SCB_OFF_CTRL, 1'b1, 32'(p / 4));
                v_set <= (p == 4 ? `SCB_VTH_HIGH : `SCB_VTH_LOW) + 16'(m[2]);
                dec_set <= m[0];
                rgn_set <= m[1];
                repeat (4) @(posedge clk);
                chk(32'(brake_on), 32'(m[2] && (p % 2 == 0 && p > 0 ||
                    (p == 1 && m[0]) || (p == 3 && m[1]))));
                v_set <= 16'h0100;
            end
    endtask
    task automatic t_fault;
        wb(`SCB_OFF_CTRL, 1'b1, 32'h0);
        wb(`SCB_OFF_BRAKE_POLICY, 1'b1, 32'h2);
        wb(`SCB_OFF_RES_MAXPWR, 1'b1, 32'h4);
        v_set <= `SCB_VOV_LOW + 16'h0002;
        repeat (4) @(posedge clk);
        h = heat_est;
        chk(32'(overvolt_fault), 32'h1);
        repeat (8) @(posedge clk);
        chk(32'(heat_est > h), 32'h1);
        v_set <= 16'h0100;
        wb(`SCB_OFF_HEAT_DECAY, 1'b1, 32'h64);
        h = heat_est;
        repeat (50) @(posedge clk);
        chk(32'(heat_est < h), 32'h1);
        wb(`SCB_OFF_STATUS, 1'b1, 32'h2);
        @(posedge clk);
        chk(32'(overvolt_fault), 32'h0);
    endtask
    task automatic t_cmd;
        int pe [7] = '{100, 2000, 100, 107, 2100, 0, 0};
        cmd_in <= '{32'sd100, 32'sd7, 32'sd2000, 32'sd55, -32'sd9};
        for (int k = 0; k < 16; k++)
        begin
            wb(`SCB_OFF_POL_INV, 1'b1, 32'(k % 8));
            infn <= '{1'b0, k[3], 1'b0};
            tick();
            chk(cmd_out.pos, (k[0] ^ k[3]) ? -100 : 100);
            chk(cmd_out.speed, k[1] ? -55 : 55);
            chk(cmd_out.torque, k[2] ? 9 : -9);
        end
        wb(`SCB_OFF_POL_INV, 1'b1, 32'h0);
        infn <= '0;
        for (int s = 0; s < 10; s++)
        begin
            wb(`SCB_OFF_POS_SRC, 1'b1, 32'(s == 7 ? 2 : s > 7 ? s - 7 : s));
            wb(`SCB_OFF_CTRL, 1'b1, 32'(s == 9 ? 2 : 0));
            infn <= '{s == 8, 1'b0, s == 7};
            tick();
            chk(cmd_out.pos, s > 7 ? 2000 * (s - 8) : s == 7 ? 2000 : pe[s]);
            chk(32'(cmd_out.pos_valid), 32'(s < 5 || s == 7 || s == 9));
        end
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_brake();
        t_fault();
        t_cmd();
        end_sim();
    end
    // Hang guard, well above the expected run
    always @(posedge clk)
    begin
        cyc_cnt++;
        if (cyc_cnt == 20000)
        begin
            n_mismatch++;
            end_sim();
        end
    end
endmodule
